// *** hdl/rmsw_ctrl.v ***
// Redundant master switch-over controller: picks master A or B for one bus segment.
// Assumes exchange strobes and output bytes come from same-clock logic, link and address
// inputs from pins, and software on an AXI4-Lite port for configuration and status.
//
// Function
// - Protocol trigger mode: after restart connect to the master that connects first.
// - Initial: neither active keeps position, both active picks A, else the active one.
// - One station address 0-99 from the selector serves both masters.
// - Application mode watches bus traffic and alive counter; failure switches to standby.
// - Automatic switch-overs only in automatic mode; manual mode keeps position.
// - Automatic switch-over only when the standby master is alive.
// - Bus failure switches after half the slave watchdog, at least 10 ms.
// - Alive counter unchanged for the application timeout causes a switch-over.
// - With both masters failed no switch-over happens.
// - Application timeout set in 10 ms steps, default 200 ms.
// - Application mode: after restart connect to the master first changing its counter.
// - 16 output bytes: byte 0 command, byte 1 alive counter, rest ignored.
// - Rising edge of command bit 0 selects A, bit 1 selects B.
// - Manual switch commands are carried out unconditionally.
// - Alive supervision stays off until the counter first changes after restart.
// - 16 input bytes: byte 0 state bits, byte 1 alive echo, rest reserved.
// - State byte: bit0 manual, bit1 on B, bit2 A alive, bit3 B alive.
// - Latest received alive counter is echoed in input byte 1.
// - Network mode: after restart connect to the master first sending alive message.
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rmsw_defs.vh"

module rmsw_ctrl #(
  parameter MS_CYCLES = `RMSW_MS_CYCLES
) (
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Per-master link and cyclic output data
  input  wire        link_up_a,
  input  wire        link_up_b,
  input  wire        xchg_a,
  input  wire        xchg_b,
  input  wire [7:0]  out_cmd_a,
  input  wire [7:0]  out_cmd_b,
  input  wire [7:0]  out_alive_a,
  input  wire [7:0]  out_alive_b,
  input  wire        alive_msg_a,
  input  wire        alive_msg_b,
  input  wire [6:0]  addr_sel,
  // Switch and cyclic input data
  output reg         switch_b,
  output reg  [6:0]  station_addr,
  output reg  [7:0]  in_state,
  output reg  [7:0]  in_echo
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and ms tick

  wire [8:0] sync_q;
  wire       lnk_a = sync_q[0];
  wire       lnk_b = sync_q[1];
  wire [6:0] addr_s = sync_q[8:2];

  rmsw_sync #(.W(9)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({addr_sel, link_up_b, link_up_a}),
    .q       (sync_q)
  );

  reg [31:0] pre_cnt;
  reg        ms_tick;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt <= 32'h00000000;
      ms_tick <= 1'b0;
    end else if (pre_cnt >= MS_CYCLES - 1) begin
      pre_cnt <= 32'h00000000;
      ms_tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 32'h00000001;
      ms_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  reg  [1:0]  trig_mode;
  reg         op_manual;
  reg  [15:0] wdog_ms;
  reg  [7:0]  appto_steps;

  wire [15:0] half_wdog = {1'b0, wdog_ms[15:1]};
  wire [15:0] bus_limit = (half_wdog < `RMSW_BUSFAIL_MIN) ? `RMSW_BUSFAIL_MIN
                                                          : half_wdog;
  wire [23:0] app_prod  = appto_steps * `RMSW_APPTO_STEP;
  wire [15:0] app_limit = (appto_steps == 8'h00) ? `RMSW_APPTO_STEP : app_prod[15:0];

  wire mode_app = (trig_mode == `RMSW_TRIG_APP);
  wire mode_net = (trig_mode == `RMSW_TRIG_NET);

  ////////////////////////////////////////////////////////////////////////////
  // Per-master output data tracking

  reg [7:0] prev_cmd_a;
  reg [7:0] prev_cmd_b;
  reg [7:0] prev_alv_a;
  reg [7:0] prev_alv_b;
  reg       seen_a;
  reg       seen_b;
  reg       started_a;
  reg       started_b;

  // Only bytes 0 and 1 are presented; reserved bytes never reach this block
  wire chg_a  = xchg_a && seen_a && (out_alive_a != prev_alv_a);
  wire chg_b  = xchg_b && seen_b && (out_alive_b != prev_alv_b);
  wire kick_a = mode_net ? alive_msg_a : chg_a;
  wire kick_b = mode_net ? alive_msg_b : chg_b;

  wire rise_a_to_a = xchg_a && seen_a && out_cmd_a[`RMSW_CMD_TO_A]
                     && !prev_cmd_a[`RMSW_CMD_TO_A];
  wire rise_a_to_b = xchg_a && seen_a && out_cmd_a[`RMSW_CMD_TO_B]
                     && !prev_cmd_a[`RMSW_CMD_TO_B];
  wire rise_b_to_a = xchg_b && seen_b && out_cmd_b[`RMSW_CMD_TO_A]
                     && !prev_cmd_b[`RMSW_CMD_TO_A];
  wire rise_b_to_b = xchg_b && seen_b && out_cmd_b[`RMSW_CMD_TO_B]
                     && !prev_cmd_b[`RMSW_CMD_TO_B];
  wire man_to_a = rise_a_to_a || rise_b_to_a;
  wire man_to_b = rise_a_to_b || rise_b_to_b;

  always @(posedge aclk) begin
    if (!aresetn) begin
      prev_cmd_a <= 8'h00;
      prev_cmd_b <= 8'h00;
      prev_alv_a <= 8'h00;
      prev_alv_b <= 8'h00;
      seen_a     <= 1'b0;
      seen_b     <= 1'b0;
      started_a  <= 1'b0;
      started_b  <= 1'b0;
      in_echo    <= 8'h00;
    end else begin
      if (xchg_a) begin
        prev_cmd_a <= out_cmd_a;
        prev_alv_a <= out_alive_a;
        seen_a     <= 1'b1;
      end
      if (xchg_b) begin
        prev_cmd_b <= out_cmd_b;
        prev_alv_b <= out_alive_b;
        seen_b     <= 1'b1;
      end
      if (xchg_b) begin
        in_echo <= out_alive_b;
      end else if (xchg_a) begin
        in_echo <= out_alive_a;
      end
      // Supervision arms on the first kick: counter change, or alive message in network mode
      if (kick_a) begin
        started_a <= 1'b1;
      end
      if (kick_b) begin
        started_b <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timeout supervisors

  wire bus_exp_a;
  wire bus_exp_b;
  wire alv_exp_a;
  wire alv_exp_b;

  rmsw_tmo u_bus_a (
    .aclk(aclk), .aresetn(aresetn), .tick(ms_tick),
    .kick(lnk_a), .limit(bus_limit), .expired(bus_exp_a)
  );
  rmsw_tmo u_bus_b (
    .aclk(aclk), .aresetn(aresetn), .tick(ms_tick),
    .kick(lnk_b), .limit(bus_limit), .expired(bus_exp_b)
  );
  rmsw_tmo u_alv_a (
    .aclk(aclk), .aresetn(aresetn), .tick(ms_tick),
    .kick(kick_a || !started_a), .limit(app_limit), .expired(alv_exp_a)
  );
  rmsw_tmo u_alv_b (
    .aclk(aclk), .aresetn(aresetn), .tick(ms_tick),
    .kick(kick_b || !started_b), .limit(app_limit), .expired(alv_exp_b)
  );

  // Alive per master as the active trigger mode sees it
  wire app_ok_a = started_a && !alv_exp_a;
  wire app_ok_b = started_b && !alv_exp_b;
  wire bus_ok_a = lnk_a && !bus_exp_a;
  wire bus_ok_b = lnk_b && !bus_exp_b;
  wire alive_a  = mode_net ? app_ok_a : (mode_app ? (app_ok_a && !bus_exp_a) : bus_ok_a);
  wire alive_b  = mode_net ? app_ok_b : (mode_app ? (app_ok_b && !bus_exp_b) : bus_ok_b);

  // Failure of the operating master; an unarmed counter never fails
  wire fail_a = bus_exp_a || ((mode_app || mode_net) && started_a && alv_exp_a);
  wire fail_b = bus_exp_b || ((mode_app || mode_net) && started_b && alv_exp_b);

  ////////////////////////////////////////////////////////////////////////////
  // Switch position

  localparam ST_INIT = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg state;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_INIT;
      switch_b <= 1'b0;
    end else begin
      case (state)
        ST_INIT: begin
          // First master to connect, alive or message wins; a tie picks A
          if (man_to_a || man_to_b) begin
            switch_b <= man_to_b && !man_to_a;
            state    <= ST_RUN;
          end else if (alive_a) begin
            switch_b <= 1'b0;
            state    <= ST_RUN;
          end else if (alive_b) begin
            switch_b <= 1'b1;
            state    <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (man_to_a) begin
            switch_b <= 1'b0;
          end else if (man_to_b) begin
            switch_b <= 1'b1;
          end else if (!op_manual) begin
            // Standby must be alive, which also blocks switching when both failed
            if (!switch_b && fail_a && alive_b) begin
              switch_b <= 1'b1;
            end else if (switch_b && fail_b && alive_a) begin
              switch_b <= 1'b0;
            end
          end
        end
        default: begin
          state <= ST_INIT;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Station address and state byte

  always @(posedge aclk) begin
    if (!aresetn) begin
      station_addr <= 7'h00;
      in_state     <= 8'h00;
    end else begin
      // Out-of-range selector settings keep the last valid address
      if (addr_s <= `RMSW_ADDR_MAX) begin
        station_addr <= addr_s;
      end
      in_state <= {4'h0, alive_b, alive_a, switch_b, op_manual};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  reg [3:0]  aw_addr;
  reg        aw_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        w_held;

  wire do_write = aw_held && w_held && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RMSW_RESP_OKAY;
      aw_addr       <= 4'h0;
      aw_held       <= 1'b0;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      w_held        <= 1'b0;
      trig_mode     <= `RMSW_TRIG_PROTO;
      op_manual     <= 1'b0;
      wdog_ms       <= `RMSW_WDOG_RST;
      appto_steps   <= `RMSW_APPTO_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RMSW_RESP_OKAY;
        case ({aw_addr[3:2], 2'b00})
          `RMSW_OFF_CTRL: begin
            if (w_strb[0]) begin
              trig_mode <= w_data[`RMSW_CTRL_MODE_HI:`RMSW_CTRL_MODE_LO];
              op_manual <= w_data[`RMSW_CTRL_MANUAL];
            end
          end
          `RMSW_OFF_WDOG: begin
            if (w_strb[0]) begin
              wdog_ms[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
              wdog_ms[15:8] <= w_data[15:8];
            end
          end
          `RMSW_OFF_APPTO: begin
            if (w_strb[0]) begin
              appto_steps <= w_data[7:0];
            end
          end
          `RMSW_OFF_STATUS: begin
            s_axi_bresp <= `RMSW_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `RMSW_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RMSW_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `RMSW_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      case ({s_axi_araddr[3:2], 2'b00})
        `RMSW_OFF_CTRL: begin
          s_axi_rdata[`RMSW_CTRL_MODE_HI:`RMSW_CTRL_MODE_LO] <= trig_mode;
          s_axi_rdata[`RMSW_CTRL_MANUAL] <= op_manual;
        end
        `RMSW_OFF_WDOG: begin
          s_axi_rdata[15:0] <= wdog_ms;
        end
        `RMSW_OFF_APPTO: begin
          s_axi_rdata[7:0] <= appto_steps;
        end
        `RMSW_OFF_STATUS: begin
          s_axi_rdata[7:0] <= in_state;
          s_axi_rdata[`RMSW_ST_ECHO_LO+7:`RMSW_ST_ECHO_LO] <= in_echo;
          s_axi_rdata[`RMSW_ST_ADDR_LO+6:`RMSW_ST_ADDR_LO] <= station_addr;
          s_axi_rdata[`RMSW_ST_INIT] <= state;
        end
        default: begin
          s_axi_rresp <= `RMSW_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // rmsw_ctrl

`default_nettype wire

// *** hdl/rmsw_defs.vh ***
// Constants for the redundant master switch-over controller.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef RMSW_DEFS_VH
`define RMSW_DEFS_VH

// Clock and time base
`define RMSW_CLK_NS        5
`define RMSW_MS_NS         1000000
`define RMSW_MS_CYCLES     (`RMSW_MS_NS / `RMSW_CLK_NS)

// Register byte offsets
`define RMSW_OFF_CTRL      4'h0
`define RMSW_OFF_WDOG      4'h4
`define RMSW_OFF_APPTO     4'h8
`define RMSW_OFF_STATUS    4'hC

// Control register fields
`define RMSW_CTRL_MODE_LO  0
`define RMSW_CTRL_MODE_HI  1
`define RMSW_CTRL_MANUAL   2

// Trigger modes
`define RMSW_TRIG_PROTO    2'h0
`define RMSW_TRIG_APP      2'h1
`define RMSW_TRIG_NET      2'h2

// Reset values
`define RMSW_WDOG_RST      16'h0064
`define RMSW_APPTO_RST     8'h14

// Timing figures in ms
`define RMSW_BUSFAIL_MIN   16'h000A
`define RMSW_APPTO_STEP    16'h000A

// Station address range
`define RMSW_ADDR_MAX      7'h63

// Output data byte 0 command bits
`define RMSW_CMD_TO_A      0
`define RMSW_CMD_TO_B      1

// Status register fields
`define RMSW_ST_ECHO_LO    8
`define RMSW_ST_ADDR_LO    16
`define RMSW_ST_INIT       24

// AXI responses
`define RMSW_RESP_OKAY     2'h0
`define RMSW_RESP_SLVERR   2'h2

`endif

// *** hdl/rmsw_sync.v ***
// Three-stage synchroniser for inputs from outside the clock domain.
// Assumes the bits are independent levels; the output follows once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none

module rmsw_sync #(
  parameter W = 1
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          q[i]  <= 1'b0;
        end else begin
          s1[i] <= d[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          // Filters a single-cycle disagreement after metastability
          if (s2[i] == s3[i]) begin
            q[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

endmodule // rmsw_sync

`default_nettype wire

// *** hdl/rmsw_tmo.v ***
// Millisecond timeout supervisor: restarts on kick, flags expiry after limit ms.
// Assumes a one-cycle ms tick from the caller and a limit of at least one.
`timescale 1ns/10ps
`default_nettype none

module rmsw_tmo (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        tick,
  input  wire        kick,
  input  wire [15:0] limit,
  output reg         expired
);

  reg [15:0] cnt;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt     <= 16'h0000;
      expired <= 1'b0;
    end else if (kick) begin
      cnt     <= 16'h0000;
      expired <= 1'b0;
    end else if (tick && !expired) begin
      // Partial first ms counts as whole, so expiry may come up to 1 ms early
      if (cnt + 16'h0001 >= limit) begin
        expired <= 1'b1;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end

endmodule // rmsw_tmo

`default_nettype wire

// *** sim/rmsw_master.sv ***
// Behavioural model of one redundant bus master feeding the switch-over controller.
// Assumes the bench steers traffic, counter and command; exchanges come every PERIOD cycles.
`timescale 1ns/10ps
`default_nettype none

module rmsw_master #(
  parameter int PERIOD = 8
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       count,
  input  wire logic [7:0] cmd,
  input  wire logic [7:0] seed,
  output wire logic       link_up,
  output wire logic       xchg,
  output wire logic [7:0] out_cmd,
  output wire logic [7:0] out_alive,
  output wire logic       alive_msg
);
  logic [7:0] alive;
  int         n;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n     <= 0;
      alive <= seed;
    end else begin
      n <= (n == PERIOD - 1) ? 0 : n + 1;
      if (xchg && count)
        alive <= alive + 8'h01;
    end
  end

  assign link_up   = run;
  assign xchg      = run && (n == PERIOD - 1);
  // Bytes are only valid with the exchange strobe; otherwise show a changing pattern
  assign out_cmd   = xchg ? cmd : ~cmd;
  assign out_alive = xchg ? alive : ~alive;
  assign alive_msg = xchg && count;
endmodule  // rmsw_master

`default_nettype wire

// *** sim/rmsw_ctrl_checker.sv ***
// Port checker for the switch-over controller: AXI timing, state byte, echo and address.
// Assumes it is bound into rmsw_ctrl and that all ports share one clock.
`timescale 1ns/10ps
`default_nettype none

module rmsw_ctrl_checker (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       xchg_b,
  input wire logic [7:0] out_alive_b,
  input wire logic [6:0] addr_sel,
  input wire logic       switch_b,
  input wire logic [6:0] station_addr,
  input wire logic [7:0] in_state,
  input wire logic [7:0] in_echo
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  aw_drop_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high after acceptance");
  b_after_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response not two cycles later");
  b_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not OKAY");
  r_after_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after address");
  state_rsv_a: assert property (in_state[7:4] == 4'h0)
    else $error("reserved state bits set");
  state_pos_a: assert property ($changed(switch_b) |=> in_state[1] == $past(switch_b))
    else $error("state bit for position lags");
  echo_b_a: assert property (xchg_b |=> in_echo == $past(out_alive_b))
    else $error("echo differs from counter of master B");
  addr_range_a: assert property (station_addr <= 7'h63)
    else $error("station address above range");
  addr_follow_a: assert property ((addr_sel <= 7'h63 && $stable(addr_sel)) [*8]
    |-> station_addr == addr_sel) else $error("station address does not follow selector");

  cover property ($rose(switch_b));
  cover property ($fell(switch_b));
  cover property (s_axi_bvalid && s_axi_bready);
endmodule  // rmsw_ctrl_checker

bind rmsw_ctrl rmsw_ctrl_checker chk_i (.*);

`default_nettype wire

// *** sim/rmsw_ctrl_bench.sv ***
// Self-checking bench: AXI4-Lite master tasks, two master models, expected switch position.
// Assumes rmsw_ctrl with a shortened millisecond tick and the constants of rmsw_defs.vh.
`timescale 1ns/10ps
`default_nettype none
`include "rmsw_defs.vh"

module rmsw_ctrl_bench;
  localparam int MS = 20;
  logic        aclk, aresetn;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        run_a, run_b, cnt_a, cnt_b, link_up_a, link_up_b, xchg_a, xchg_b;
  logic        alive_msg_a, alive_msg_b, switch_b;
  logic [7:0]  cmd_a, cmd_b, seed_a, seed_b, out_cmd_a, out_cmd_b, out_alive_a, out_alive_b;
  logic [7:0]  in_state, in_echo;
  logic [6:0]  addr_sel, station_addr, last_addr;
  int          fails, cmp_count, exp_sw;

  rmsw_ctrl #(.MS_CYCLES(MS)) dut (.*);
  // A answers quickly, B slowly
  rmsw_master #(.PERIOD(7)) ma (.aclk, .aresetn, .run(run_a), .count(cnt_a), .cmd(cmd_a),
    .seed(seed_a), .link_up(link_up_a), .xchg(xchg_a), .out_cmd(out_cmd_a),
    .out_alive(out_alive_a), .alive_msg(alive_msg_a));
  rmsw_master #(.PERIOD(11)) mb (.aclk, .aresetn, .run(run_b), .count(cnt_b), .cmd(cmd_b),
    .seed(seed_b), .link_up(link_up_b), .xchg(xchg_b), .out_cmd(out_cmd_b),
    .out_alive(out_alive_b), .alive_msg(alive_msg_b));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic axw(logic [3:0] a, logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, 32'h0);
    // Let an edge pass so a following call never re-raises bready in this step
    @(posedge aclk);
  endtask

  task automatic rchk(logic [3:0] a, logic [31:0] exp);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, exp);
    chk("rresp", s_axi_rresp, 32'h0);
    @(posedge aclk);
  endtask

  task automatic do_reset;
    aresetn <= 1'b0;
    {run_a, run_b, cnt_a, cnt_b, cmd_a, cmd_b} <= '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    exp_sw = 0;
  endtask

  task automatic wait_n(int n);
    repeat (n) @(posedge aclk);
  endtask

  // Position must hold for lo cycles and have moved to nsw by hi cycles
  task automatic win(int lo, int hi, int nsw);
    wait_n(lo);
    chk("switch_b early", switch_b, exp_sw);
    wait_n(hi - lo);
    exp_sw = nsw;
    chk("switch_b", switch_b, exp_sw);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    fails = 0;
    cmp_count = 0;
    void'($urandom(32'h5CAECDD1));
    addr_sel = 7'($urandom % 100);
    seed_a = 8'($urandom);
    seed_b = 8'($urandom);
    do_reset;
    rchk(`RMSW_OFF_CTRL, 32'h0);
    rchk(`RMSW_OFF_WDOG, 32'h64);
    rchk(`RMSW_OFF_APPTO, 32'h14);
    wait_n(8);
    chk("station_addr", station_addr, addr_sel);
    last_addr = addr_sel;
    addr_sel <= 7'd100 + 7'($urandom % 28);
    wait_n(10);
    chk("station_addr held", station_addr, last_addr);
    // Protocol mode: B connects first, then manual commands
    run_b <= 1'b1;
    wait_n(12);
    exp_sw = 1;
    chk("switch_b", switch_b, exp_sw);
    run_a <= 1'b1;
    wait_n(30);
    cmd_a <= 8'h01;
    wait_n(12);
    exp_sw = 0;
    chk("switch_b", switch_b, exp_sw);
    cmd_b <= 8'h03;
    wait_n(40);
    chk("switch_b", switch_b, exp_sw);
    cmd_b <= 8'h00;
    wait_n(30);
    cmd_b <= 8'h02;
    wait_n(16);
    exp_sw = 1;
    chk("switch_b", switch_b, exp_sw);
    chk("in_state", in_state, 32'h0E);
    cmd_a <= 8'h00;
    cmd_b <= 8'h00;
    // Bus failure of the operating master, half watchdog and its floor
    axw(`RMSW_OFF_WDOG, 32'd40);
    run_b <= 1'b0;
    win(19 * MS, 20 * MS + 8, 0);
    run_b <= 1'b1;
    wait_n(20);
    axw(`RMSW_OFF_WDOG, 32'd4);
    run_a <= 1'b0;
    win(9 * MS, 10 * MS + 8, 1);
    // Manual mode blocks automatic switching
    axw(`RMSW_OFF_CTRL, 32'h4);
    run_a <= 1'b1;
    wait_n(20);
    run_b <= 1'b0;
    wait_n(15 * MS);
    chk("switch_b manual", switch_b, exp_sw);
    chk("in_state", in_state, 32'h07);
    run_a <= 1'b0;
    wait_n(15 * MS);
    axw(`RMSW_OFF_CTRL, 32'h0);
    wait_n(15 * MS);
    chk("switch_b both failed", switch_b, exp_sw);
    // Application mode: supervision armed by first counter change
    do_reset;
    axw(`RMSW_OFF_CTRL, 32'h1);
    axw(`RMSW_OFF_APPTO, 32'h1);
    run_a <= 1'b1;
    run_b <= 1'b1;
    wait_n(15 * MS);
    chk("switch_b unarmed", switch_b, exp_sw);
    cnt_b <= 1'b1;
    wait_n(40);
    exp_sw = 1;
    chk("switch_b", switch_b, exp_sw);
    cnt_a <= 1'b1;
    wait_n(40);
    cnt_b <= 1'b0;
    win(9 * MS, 10 * MS + 24, 0);
    run_b <= 1'b0;
    cnt_a <= 1'b0;
    wait_n(30);
    chk("in_echo", in_echo, ma.alive);
    // Network mode: first alive telegram wins
    do_reset;
    axw(`RMSW_OFF_CTRL, 32'h2);
    run_a <= 1'b1;
    run_b <= 1'b1;
    cnt_b <= 1'b1;
    wait_n(40);
    exp_sw = 1;
    chk("switch_b", switch_b, exp_sw);
    test_done;
  end

  // The run needs about 2500 cycles; allow eight times that before giving up
  initial begin
    #100000;
    fails++;
    test_done;
  end
endmodule  // rmsw_ctrl_bench

`default_nettype wire
